/* File: hw/console_port.sv */
//------------------------------------------------------------------
// operator console port of the computing element
//------------------------------------------------------------------
// drives the console lamps from processor state and turns console
// switches and keys into requests toward the processor; commands other than activate as one-cycle pulses.
// assumes processor side signals are on clk_sys; console pins are
// asynchronous and quasi-static.
`timescale 1ns/1ps
`include "console_cfg.svh"
module console_port #(
    parameter int CHK_N = 4
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    // processor side
    input wire console_pkg::proc_status_s proc_status,
    input wire logic [`DATA_W-1:0] display_operand,
    input wire logic [`ADDR_W-1:0] instruction_counter,
    input wire logic state_bit_high,
    input wire logic state_bit_low,
    input wire logic [CHK_N-1:0] logic_check_conds,
    input wire logic [`ADDR_W-1:0] storage_limit,
    // console pins
    input wire console_pkg::console_in_s console_in,
    // lamps toward the console
    output logic load_ind,
    output logic [`DATA_W-1:0] data_ind,
    output logic [`ADDR_W-1:0] ic_ind,
    output logic manual_ind,
    output logic wait_ind,
    output logic [`STATE_N-1:0] state_lines,
    output logic logic_check,
    output logic power_check,
    output logic battery,
    output logic invalid_storage,
    // requests toward the processor
    output logic stop_req,
    output logic start_req,
    output logic step_mode,
    output logic manual_strobe,
    output console_pkg::manual_req_s manual_req,
    output logic ext_int_set,
    output logic addr_cmp_req,
    output logic addr_cmp_process,
    output logic ipl_start,
    output console_pkg::ipl_sel_s ipl_sel,
    output logic [`AUTH_W-1:0] configuration_authority_bits
);
    import console_pkg::*;

    //------------------------------------------------------------------
    // synchronised console pins
    //------------------------------------------------------------------
    console_in_s cin;
    console_cmd_s prev_cmd_ff;
    console_cmd_s rise;
    logic take;

    console_sync #(
        .W($bits(console_in_s))
    ) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin(console_in),
        .level(cin)
    );

    // edges of settled command lines; a held switch fires once
    assign rise = cin.cmd & ~prev_cmd_ff; // RULE23
    // select gates every command except all-stop
    assign take = cin.select; // RULE11

    //------------------------------------------------------------------
    // indicator lamps
    //------------------------------------------------------------------
    logic load_ff, manual_ff, wait_ff, lchk_ff, pchk_ff, batt_ff, inv_ff;
    logic nxt_load, nxt_manual, nxt_wait, nxt_lchk, nxt_pchk, nxt_batt, nxt_inv;
    logic [`DATA_W-1:0] data_ff, nxt_data;
    logic [`ADDR_W-1:0] ic_ff, nxt_ic;

    // lamps follow processor state with one register of delay
    always_comb begin
        nxt_load = proc_status.ipl_busy; // RULE1
        nxt_data = display_operand; // RULE2
        nxt_ic = instruction_counter; // RULE3
        nxt_manual = proc_status.stopped; // RULE4
        nxt_wait = proc_status.waiting; // RULE5
        nxt_lchk = |logic_check_conds; // RULE7
        // warning comes before thermal shutdown, so software still has time
        nxt_pchk = proc_status.temp_warn | proc_status.volt_loss
            | proc_status.normal_off; // RULE8
        nxt_batt = proc_status.on_battery; // RULE9
        // keyed address beyond installed storage is flagged without a command key, one register after the synchroniser
        nxt_inv = cin.addr_keys >= storage_limit; // RULE10
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_ff <= 1'b0;
            data_ff <= '0;
            ic_ff <= '0;
            manual_ff <= 1'b0;
            wait_ff <= 1'b0;
            lchk_ff <= 1'b0;
            pchk_ff <= 1'b0;
            batt_ff <= 1'b0;
            inv_ff <= 1'b0;
        end else begin
            load_ff <= nxt_load;
            data_ff <= nxt_data;
            ic_ff <= nxt_ic;
            manual_ff <= nxt_manual;
            wait_ff <= nxt_wait;
            lchk_ff <= nxt_lchk;
            pchk_ff <= nxt_pchk;
            batt_ff <= nxt_batt;
            inv_ff <= nxt_inv;
        end
    end

    console_state_decode u_state (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .state_bit_high(state_bit_high),
        .state_bit_low(state_bit_low),
        .state_lines(state_lines)
    );

    assign load_ind = load_ff;
    assign data_ind = data_ff;
    assign ic_ind = ic_ff;
    assign manual_ind = manual_ff;
    assign wait_ind = wait_ff;
    assign logic_check = lchk_ff;
    assign power_check = pchk_ff;
    assign battery = batt_ff;
    assign invalid_storage = inv_ff;

    //------------------------------------------------------------------
    // console commands
    //------------------------------------------------------------------
    logic stop_ff, start_ff, step_ff, mstb_ff, int_ff, cmp_ff, cmpp_ff, ipl_ff;
    logic nxt_stop, nxt_start, nxt_step, nxt_mstb, nxt_int, nxt_cmp, nxt_cmpp, nxt_ipl;
    manual_req_s mreq_ff, nxt_mreq;
    ipl_sel_s isel_ff, nxt_isel;
    logic [`AUTH_W-1:0] auth_ff, nxt_auth;

    // one pulse per console action; if two operation keys rise in the
    // same cycle, display wins over store, store over set counter
    always_comb begin
        nxt_stop = rise.all_stop | (take & rise.stop); // RULE22 RULE12
        nxt_start = take & rise.start; // RULE12
        nxt_step = take ? cin.rate : step_ff; // RULE19
        nxt_mstb = take & (rise.display | rise.store | rise.set_ic); // RULE16
        nxt_mreq = mreq_ff;
        if (nxt_mstb) begin
            if (rise.display) begin
                nxt_mreq.op = MOP_DISPLAY;
            end else if (rise.store) begin
                nxt_mreq.op = MOP_STORE;
            end else begin
                nxt_mreq.op = MOP_SET_IC;
            end
            nxt_mreq.addr = cin.addr_keys; // RULE13
            nxt_mreq.data = cin.data_keys; // RULE14
            nxt_mreq.storage_space = cin.storage_select; // RULE15
        end
        nxt_int = take & rise.interrupt; // RULE17
        // either line starts a compare; line 1 is the process position
        nxt_cmp = take & (|rise.addr_cmp); // RULE18
        nxt_cmpp = nxt_cmp ? rise.addr_cmp[1] : cmpp_ff;
        nxt_ipl = take & rise.load; // RULE20
        nxt_isel = nxt_ipl
            ? ipl_sel_s'{chan: cin.chan, unit: cin.unit, elem: cin.elem} : isel_ff;
        nxt_auth = (take & rise.activate) ? cin.control : auth_ff; // RULE21
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_cmd_ff <= '0;
            stop_ff <= 1'b0;
            start_ff <= 1'b0;
            step_ff <= 1'b0;
            mstb_ff <= 1'b0;
            mreq_ff <= '0;
            int_ff <= 1'b0;
            cmp_ff <= 1'b0;
            cmpp_ff <= 1'b0;
            ipl_ff <= 1'b0;
            isel_ff <= '0;
            auth_ff <= `AUTH_RST;
        end else begin
            prev_cmd_ff <= cin.cmd;
            stop_ff <= nxt_stop;
            start_ff <= nxt_start;
            step_ff <= nxt_step;
            mstb_ff <= nxt_mstb;
            mreq_ff <= nxt_mreq;
            int_ff <= nxt_int;
            cmp_ff <= nxt_cmp;
            cmpp_ff <= nxt_cmpp;
            ipl_ff <= nxt_ipl;
            isel_ff <= nxt_isel;
            auth_ff <= nxt_auth;
        end
    end

    assign stop_req = stop_ff;
    assign start_req = start_ff;
    assign step_mode = step_ff;
    assign manual_strobe = mstb_ff;
    assign manual_req = mreq_ff;
    assign ext_int_set = int_ff;
    assign addr_cmp_req = cmp_ff;
    assign addr_cmp_process = cmpp_ff;
    assign ipl_start = ipl_ff;
    assign ipl_sel = isel_ff;
    assign configuration_authority_bits = auth_ff;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_activate_taken;
        take && rise.activate;
    endsequence

    property p_load_lamp;
        proc_status.ipl_busy |=> load_ind;
    endproperty
    a_load_lamp: assert property (p_load_lamp) else $error("load lamp dark during load"); // RULE1

    property p_data_lamps;
        1'b1 |=> data_ind == $past(display_operand);
    endproperty
    a_data_lamps: assert property (p_data_lamps) else $error("data lamps stale"); // RULE2

    property p_ic_lamps;
        1'b1 |=> ic_ind == $past(instruction_counter);
    endproperty
    a_ic_lamps: assert property (p_ic_lamps) else $error("counter lamps stale"); // RULE3

    property p_manual_wait;
        (proc_status.stopped && !proc_status.waiting) |=> manual_ind && !wait_ind;
    endproperty
    a_manual_wait: assert property (p_manual_wait) else $error("manual or wait lamp wrong"); // RULE4

    property p_state_onehot;
        1'b1 |=> ##1 $onehot(state_lines)
            && state_lines[{$past(state_bit_high), $past(state_bit_low)}];
    endproperty
    a_state_onehot: assert property (p_state_onehot) else $error("state lines not one-hot"); // RULE6

    property p_unselected;
        !take |=> !start_req && !manual_strobe && !ipl_start && !ext_int_set;
    endproperty
    a_unselected: assert property (p_unselected) else $error("command taken unselected"); // RULE11

    property p_all_stop;
        rise.all_stop |=> stop_req;
    endproperty
    a_all_stop: assert property (p_all_stop) else $error("all-stop ignored"); // RULE22

    property p_activate;
        s_activate_taken |=> configuration_authority_bits == $past(cin.control);
    endproperty
    a_activate: assert property (p_activate) else $error("authority bits not loaded"); // RULE21

    property p_start_once;
        start_req |=> !start_req;
    endproperty
    a_start_once: assert property (p_start_once) else $error("start taken twice"); // RULE23

endmodule

/* File: inc/console_cfg.svh */
//------------------------------------------------------------------
// console port constants
//------------------------------------------------------------------
// field widths and reset values for the operator console port.
// assumes inclusion from console_pkg, the design files and the bench, guarded once per compile.
//
// Contract
// RULE1: load lamp lit while loading runs
// RULE2: 36 data lamps show display operand
// RULE3: 27 lamps show instruction counter
// RULE4: manual lamp follows stopped state
// RULE5: wait lamp follows wait state
// RULE6: two state bits decode one-hot
// RULE7: logic check lamp on any check
// RULE8: power check on heat, volts, off
// RULE9: battery lamp while on battery
// RULE10: invalid storage lamp on bad address
// RULE11: act on commands only when selected
// RULE12: stop and start pulses when selected
// RULE13: address keys feed manual operations
// RULE14: data keys feed manual store
// RULE15: storage select marks storage address
// RULE16: display, store, set counter operations
// RULE17: interrupt pulse sets external interruption
// RULE18: address compare from two lines
// RULE19: rate line picks normal or step
// RULE20: load line starts initial program load
// RULE21: activate copies control lines to authority
// RULE22: all-stop stops regardless of select
// RULE23: synchronise inputs, take each once
`ifndef CONSOLE_CFG_SVH
`define CONSOLE_CFG_SVH

`define DATA_W 36
`define ADDR_W 27
`define CHAN_W 5
`define UNIT_W 9
`define ELEM_W 5
`define AUTH_W 3
`define STATE_N 4
`define AUTH_RST 3'h0
`define STATE_RST 4'h0

`endif

/* File: inc/console_pkg.sv */
//------------------------------------------------------------------
// console port types
//------------------------------------------------------------------
// packed carriers for console pins, processor status and requests.
// assumes console_cfg.svh is on the include path.
package console_pkg;
`include "console_cfg.svh"

    // command lines, each taken on its rising edge
    typedef struct packed {
        logic stop;
        logic start;
        logic display;
        logic store;
        logic set_ic;
        logic interrupt;
        logic [1:0] addr_cmp;
        logic load;
        logic activate;
        logic all_stop;
    } console_cmd_s;

    // everything the console drives toward the processor
    typedef struct packed {
        logic select;
        logic rate;
        logic storage_select;
        logic [`ADDR_W-1:0] addr_keys;
        logic [`DATA_W-1:0] data_keys;
        logic [`CHAN_W-1:0] chan;
        logic [`UNIT_W-1:0] unit;
        logic [`ELEM_W-1:0] elem;
        logic [`AUTH_W-1:0] control;
        console_cmd_s cmd;
    } console_in_s;

    typedef enum logic [1:0] {MOP_DISPLAY, MOP_STORE, MOP_SET_IC} manual_op_e;

    typedef struct packed {
        manual_op_e op;
        logic storage_space;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
    } manual_req_s;

    typedef struct packed {
        logic [`CHAN_W-1:0] chan;
        logic [`UNIT_W-1:0] unit;
        logic [`ELEM_W-1:0] elem;
    } ipl_sel_s;

    typedef struct packed {
        logic stopped;
        logic waiting;
        logic ipl_busy;
        logic temp_warn;
        logic volt_loss;
        logic normal_off;
        logic on_battery;
    } proc_status_s;

endpackage

/* File: hw/console_sync.sv */
//------------------------------------------------------------------
// three-stage pin synchroniser
//------------------------------------------------------------------
// brings console pins into clk_sys; a bit changes once stages two
// and three agree. assumes pins are quasi-static switches and keys.
`timescale 1ns/1ps
module console_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    import console_pkg::*;

    logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
    logic [W-1:0] nxt_out;

    // hold the old value on disagreement, so a glitch through
    // stage two alone never reaches the edge detectors
    always_comb begin
        nxt_out = (s3_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff)); // RULE23
    end

    // stage one is read only by stage two
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= pin;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign level = out_ff;
endmodule

/* File: hw/console_state_decode.sv */
//------------------------------------------------------------------
// configuration state decoder
//------------------------------------------------------------------
// turns the two configuration state bits into four lamp lines.
// assumes the state bits come from logic on clk_sys.
`timescale 1ns/1ps
`include "console_cfg.svh"
module console_state_decode (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic state_bit_high,
    input wire logic state_bit_low,
    output logic [`STATE_N-1:0] state_lines
);
    import console_pkg::*;

    logic [`STATE_N-1:0] lines_ff, nxt_lines;

    // index 3: both one, 2: high only, 1: low only, 0: both zero
    always_comb begin
        nxt_lines = '0;
        nxt_lines[{state_bit_high, state_bit_low}] = 1'b1; // RULE6
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lines_ff <= `STATE_RST;
        end else begin
            lines_ff <= nxt_lines;
        end
    end

    assign state_lines = lines_ff;
endmodule

/* File: bench/console_model.sv */
//------------------------------------------------------------
// operator console model
//------------------------------------------------------------
// switches, keys and command lines of the operator console.
// assumes the bench calls press and set_keys just after a clk_sys
// rising edge, and never both in the same time step.
`timescale 1ns/1ps
module console_model (
    input wire logic clk_sys,
    output console_pkg::console_in_s console_in
);
    import console_pkg::*;
    int hold_cnt = 0;

    initial begin
        console_in = '0;
    end

    // a command key is held 6 cycles: long enough to clear the sync
    task automatic press(input console_cmd_s c);
        console_in.cmd <= c;
        hold_cnt <= 6;
    endtask

    // keys are levels; the select switch addresses this processor
    task automatic set_keys(input console_in_s k);
        k.cmd = console_in.cmd;
        console_in <= k;
    endtask

    // release the command key once the hold time has run out
    always @(posedge clk_sys) begin
        if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
            if (hold_cnt == 1) begin
                console_in.cmd <= '0;
            end
        end
    end
endmodule

/* File: bench/processor_operator_console_port_bench.sv */
//------------------------------------------------------------
// console port bench
//------------------------------------------------------------
// self-checking scenarios for lamps and console commands.
// assumes console_pkg and the design files are compiled first.
`timescale 1ns/1ps
`include "console_cfg.svh"
module processor_operator_console_port_bench;
    import console_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    proc_status_s proc_status = '0;
    logic [`DATA_W-1:0] display_operand = '0;
    logic [`ADDR_W-1:0] instruction_counter = '0;
    logic state_bit_high = 1'b0;
    logic state_bit_low = 1'b0;
    logic [3:0] logic_check_conds = '0;
    logic [`ADDR_W-1:0] storage_limit = 27'h4000000;
    console_in_s console_in;
    console_in_s keys = '0;
    logic load_ind, manual_ind, wait_ind, logic_check, power_check, battery, invalid_storage;
    logic [`DATA_W-1:0] data_ind;
    logic [`ADDR_W-1:0] ic_ind;
    logic [3:0] state_lines;
    logic stop_req, start_req, step_mode, manual_strobe, ext_int_set;
    logic addr_cmp_req, addr_cmp_process, ipl_start;
    manual_req_s manual_req;
    ipl_sel_s ipl_sel;
    logic [2:0] auth;
    int n_mismatch = 0;
    int n_compared = 0;
    wire [5:0] pulses = {ipl_start, addr_cmp_req, ext_int_set, manual_strobe, start_req, stop_req};
    manual_op_e ops [3] = '{MOP_DISPLAY, MOP_STORE, MOP_SET_IC};

    always #2 clk_sys = ~clk_sys;

    console_model i_console_model (.clk_sys(clk_sys), .console_in(console_in));

    console_port i_console_port (
        .clk_sys(clk_sys), .arst_n(arst_n), .proc_status(proc_status),
        .display_operand(display_operand), .instruction_counter(instruction_counter),
        .state_bit_high(state_bit_high), .state_bit_low(state_bit_low),
        .logic_check_conds(logic_check_conds), .storage_limit(storage_limit),
        .console_in(console_in), .load_ind(load_ind), .data_ind(data_ind),
        .ic_ind(ic_ind), .manual_ind(manual_ind), .wait_ind(wait_ind),
        .state_lines(state_lines), .logic_check(logic_check), .power_check(power_check),
        .battery(battery), .invalid_storage(invalid_storage), .stop_req(stop_req),
        .start_req(start_req), .step_mode(step_mode), .manual_strobe(manual_strobe),
        .manual_req(manual_req), .ext_int_set(ext_int_set), .addr_cmp_req(addr_cmp_req),
        .addr_cmp_process(addr_cmp_process), .ipl_start(ipl_start), .ipl_sel(ipl_sel),
        .configuration_authority_bits(auth)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // sample 1 ns after the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic apply_keys();
        @(posedge clk_sys);
        i_console_model.set_keys(keys);
        tick(8);
    endtask

    // press one command and count its request pulses over 20 cycles
    task automatic cmd_check(input string what, input console_cmd_s c, input int idx,
                             input int n_exp);
        int n;
        n = 0;
        @(posedge clk_sys);
        i_console_model.press(c);
        repeat (20) begin
            tick(1);
            if (pulses[idx] === 1'b1) n++;
        end
        check(what, n, n_exp);
    endtask

    task automatic t_lamps();
        @(posedge clk_sys);
        proc_status <= proc_status_s'(7'h51);
        display_operand <= 36'h9a5c30f1e;
        instruction_counter <= 27'h5a5a5a5;
        logic_check_conds <= 4'h4;
        tick(3);
        check("load", load_ind, 1);
        check("data", data_ind, 36'h9a5c30f1e);
        check("ic", ic_ind, 27'h5a5a5a5);
        check("manual", manual_ind, 1);
        check("wait", wait_ind, 0);
        check("lchk", logic_check, 1);
        check("batt", battery, 1);
        check("pchk", power_check, 0);
        @(posedge clk_sys);
        proc_status <= proc_status_s'(7'h20);
        logic_check_conds <= 4'h0;
        tick(3);
        check("manual", manual_ind, 0);
        check("wait", wait_ind, 1);
        check("lchk", logic_check, 0);
        check("load", load_ind, 0);
        // heat warning, voltage loss and normal off one at a time
        for (int i = 1; i < 4; i++) begin
            @(posedge clk_sys);
            proc_status <= proc_status_s'(7'h10 >> i);
            tick(3);
            check("pchk", power_check, 1);
        end
    endtask

    task automatic t_state();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            state_bit_high <= i[1];
            state_bit_low <= i[0];
            tick(3);
            check("state", state_lines, 4'h1 << i);
        end
    endtask

    task automatic t_keyed();
        console_cmd_s c;
        @(posedge clk_sys);
        storage_limit <= 27'h100;
        keys.select = 1'b1;
        keys.addr_keys = 27'hff;
        apply_keys();
        check("inval", invalid_storage, 0);
        keys.addr_keys = 27'h100;
        keys.data_keys = 36'h123456789;
        keys.storage_select = 1'b1;
        keys.chan = 5'h15;
        keys.unit = 9'h1a3;
        keys.elem = 5'h0b;
        keys.control = 3'h5;
        keys.rate = 1'b1;
        apply_keys();
        check("inval", invalid_storage, 1);
        check("step", step_mode, 1);
        for (int i = 0; i < 3; i++) begin
            c = '0;
            c.display = (i == 0);
            c.store = (i == 1);
            c.set_ic = (i == 2);
            cmd_check("mstrobe", c, 2, 1);
            check("op", manual_req.op, ops[i]);
            check("maddr", manual_req.addr, 27'h100);
            check("mdata", manual_req.data, 36'h123456789);
            check("mspace", manual_req.storage_space, 1);
        end
        keys.addr_keys = 27'h3;
        apply_keys();
        check("maddr", manual_req.addr, 27'h100);
        c = '0;
        c.stop = 1'b1;
        cmd_check("stop", c, 0, 1);
        c = '0;
        c.start = 1'b1;
        cmd_check("start", c, 1, 1);
        c = '0;
        c.interrupt = 1'b1;
        cmd_check("extint", c, 3, 1);
        for (int i = 0; i < 2; i++) begin
            c = '0;
            c.addr_cmp[i] = 1'b1;
            cmd_check("acmp", c, 4, 1);
            check("aproc", addr_cmp_process, i);
        end
        c = '0;
        c.load = 1'b1;
        cmd_check("ipl", c, 5, 1);
        check("iplsel", ipl_sel, {5'h15, 9'h1a3, 5'h0b});
        c = '0;
        c.activate = 1'b1;
        cmd_check("activate", c, 0, 0);
        check("auth", auth, 3'h5);
        keys.rate = 1'b0;
        apply_keys();
        check("step", step_mode, 0);
    endtask

    // deselected: commands are ignored, all-stop still stops
    task automatic t_unselected();
        console_cmd_s c;
        keys.select = 1'b0;
        keys.control = 3'h2;
        apply_keys();
        c = '0;
        c.start = 1'b1;
        cmd_check("start", c, 1, 0);
        c = '0;
        c.display = 1'b1;
        cmd_check("mstrobe", c, 2, 0);
        c = '0;
        c.activate = 1'b1;
        cmd_check("activate", c, 0, 0);
        check("auth", auth, 3'h5);
        c = '0;
        c.all_stop = 1'b1;
        cmd_check("allstop", c, 0, 1);
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        tick(2);
        t_lamps();
        t_state();
        t_keyed();
        t_unselected();
        give_verdict();
    end

    // the scenarios need about 380 cycles; 20000 means a hang
    initial begin
        #80000;
        n_mismatch++;
        give_verdict();
    end
endmodule
